// ---- inc/vq_pkg.sv ----
// Purpose: shared constants and types for the output crop and quantize stage
// Assumes: 12-bit 10.2 samples, 32-bit classic Wishbone register bus
// Notes:   limits are stored in the units of the rounded result
`default_nettype none
package vq_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_HWIN = 8'h04;
  localparam logic [7:0] REG_VWIN = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;

  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_QSEL_LSB = 4;
  localparam int CTRL_TRS_BIT  = 8;
  localparam int WIN_FIRST_LSB = 0;
  localparam int WIN_SIZE_LSB  = 16;
  localparam int STAT_PIX_LSB  = 0;
  localparam int STAT_LINE_LSB = 16;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] HWIN_RST = 32'h0000_0000;
  localparam logic [31:0] VWIN_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Sample format and levels
  // ----------------------------------------------------------------
  localparam int CW      = 12;
  localparam int SHIFT10 = 2;
  localparam int SHIFT8  = 4;
  localparam logic [12:0] RND10 = 13'h0002;
  localparam logic [12:0] RND8  = 13'h0008;

  localparam logic [11:0] BLANK_Y = 12'h100;
  localparam logic [11:0] BLANK_C = 12'h800;

  localparam logic [10:0] L10A_LO   = 11'h000;
  localparam logic [10:0] L10A_HI   = 11'h3FF;
  localparam logic [10:0] L10B_LO   = 11'h004;
  localparam logic [10:0] L10B_HI   = 11'h3FB;
  localparam logic [10:0] L10C_LO   = 11'h040;
  localparam logic [10:0] L10C_Y_HI = 11'h3AC;
  localparam logic [10:0] L10C_C_HI = 11'h3C0;
  localparam logic [10:0] L8A_LO    = 11'h000;
  localparam logic [10:0] L8A_HI    = 11'h0FF;
  localparam logic [10:0] L8B_LO    = 11'h001;
  localparam logic [10:0] L8B_HI    = 11'h0FE;
  localparam logic [10:0] L8C_LO    = 11'h010;
  localparam logic [10:0] L8C_Y_HI  = 11'h0EB;
  localparam logic [10:0] L8C_C_HI  = 11'h0F0;

  typedef enum logic [2:0] {
    Q_FULL = 3'h0,
    Q_10A  = 3'h1,
    Q_10B  = 3'h2,
    Q_10C  = 3'h3,
    Q_RSVD = 3'h4,
    Q_8A   = 3'h5,
    Q_8B   = 3'h6,
    Q_8C   = 3'h7
  } qsel_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  // Incoming stream: flags plus luma and chroma words
  typedef struct packed {
    logic        h_act;
    logic        v_act;
    logic        field;
    logic        eav;
    logic [11:0] y;
    logic [11:0] c;
  } vid_in_t;

  // Outgoing stream: cropped timing flags plus words
  typedef struct packed {
    logic        h_out;
    logic        v_out;
    logic        f_out;
    logic [11:0] y;
    logic [11:0] c;
  } vid_out_t;
endpackage
`default_nettype wire

// ---- hw/span_counter.sv ----
// Purpose: position counter that restarts and advances on strobes
// Assumes: restart has priority over advance
// Notes:   saturates at all ones instead of wrapping
`default_nettype none
module span_counter #(
  parameter int W = 12
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         restart,
  input  wire logic         advance,
  output logic [W-1:0]      cnt,
  output logic [W-1:0]      cnt_next
);
  logic [W-1:0] cnt_reg;

  wire at_max = &cnt_reg;

  assign cnt_next = restart ? '0 :
                    (advance && !at_max) ? cnt_reg + 1'b1 : cnt_reg;
  assign cnt = cnt_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// ---- hw/sample_quantizer.sv ----
// Purpose: round and clip one 10.2 sample to the selected range
// Assumes: input is 10.2 unsigned or offset binary
// Notes:   result stays left aligned in a 12-bit word
`default_nettype none
module sample_quantizer (
  input  wire vq_pkg::qsel_t sel,
  input  wire logic          is_chroma,
  input  wire logic [11:0]   din,
  output logic [11:0]        dout
);
  wire [12:0] r10 = {1'b0, din} + vq_pkg::RND10;
  wire [12:0] r8  = {1'b0, din} + vq_pkg::RND8;
  wire [10:0] v10 = r10[12:2];
  wire [10:0] v8  = {2'b00, r8[12:4]};

  logic [10:0] val;
  logic [10:0] lo;
  logic [10:0] hi;
  logic [10:0] clip;
  logic        eight;

  always_comb begin
    val   = v10;
    lo    = vq_pkg::L10A_LO;
    hi    = vq_pkg::L10A_HI;
    eight = 1'b0;
    case (sel)
      vq_pkg::Q_10A: begin
        lo = vq_pkg::L10A_LO;
        hi = vq_pkg::L10A_HI;
      end
      vq_pkg::Q_10B: begin
        lo = vq_pkg::L10B_LO;
        hi = vq_pkg::L10B_HI;
      end
      vq_pkg::Q_10C: begin
        lo = vq_pkg::L10C_LO;
        hi = is_chroma ? vq_pkg::L10C_C_HI : vq_pkg::L10C_Y_HI;
      end
      vq_pkg::Q_8A: begin
        val = v8; eight = 1'b1;
        lo = vq_pkg::L8A_LO;
        hi = vq_pkg::L8A_HI;
      end
      vq_pkg::Q_8B: begin
        val = v8; eight = 1'b1;
        lo = vq_pkg::L8B_LO;
        hi = vq_pkg::L8B_HI;
      end
      vq_pkg::Q_8C: begin
        val = v8; eight = 1'b1;
        lo = vq_pkg::L8C_LO;
        hi = is_chroma ? vq_pkg::L8C_C_HI : vq_pkg::L8C_Y_HI;
      end
      default: begin
        val = v10;
      end
    endcase
    clip = (val < lo) ? lo : (val > hi) ? hi : val;
    case (sel)
      vq_pkg::Q_FULL, vq_pkg::Q_RSVD: dout = din;
      default: dout = eight ? {clip[7:0], 4'h0} : {clip[9:0], 2'h0};
    endcase
  end
endmodule
`default_nettype wire

// ---- hw/crop_quant_top.sv ----
// Purpose: output crop window, cropped timing flags and output quantizing
// Assumes: one pixel per clock, flags and words synchronous to core_clk
// Notes:   one cycle from input sample to output word and flags
//
// Functional notes
// - Blank every active sample outside window
// - Timing flags frame the cropped picture
// - Embedded timing words keep original positions
// - Crop only while cut enable set
// - Blank left pixel count each line
// - Keep pixel count, blank rest of line
// - Blank top line count each field
// - Keep line count, blank remaining lines
// - Timing flags always driven, even embedded
// - Vertical and field flags change on EAV
// - Output words are 12-bit 10.2
// - Luma unsigned, chroma offset binary
// - Select zero rounds to 10.2, full
// - Select 001 rounds 10-bit, 0..1023
// - Select 010 rounds 10-bit, 4..1019
// - Select 011 luma 64..940, chroma 64..960
// - Select 101 rounds 8-bit, 0..255
// - Select 110 rounds 8-bit, 1..254
// - Select 111 luma 16..235, chroma 16..240
//
// Implementation choices: the address map and the Wishbone register port.
`default_nettype none
module crop_quant_top #(
  parameter int CNT_W = 12
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire vq_pkg::vid_in_t   vin,
  output var vq_pkg::vid_out_t   vout
);
  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  vq_pkg::bus_state_t bus_state_reg;
  logic [31:0]        ctrl_reg;
  logic [31:0]        hwin_reg;
  logic [31:0]        vwin_reg;
  logic [31:0]        rdata_reg;

  function automatic logic [31:0] lanes(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  wire req      = wb_cyc_i && wb_stb_i && (bus_state_reg == vq_pkg::BUS_IDLE);
  wire wr       = req && wb_we_i;
  wire hit_ctrl = (wb_adr_i == vq_pkg::REG_CTRL);
  wire hit_hwin = (wb_adr_i == vq_pkg::REG_HWIN);
  wire hit_vwin = (wb_adr_i == vq_pkg::REG_VWIN);
  wire hit_stat = (wb_adr_i == vq_pkg::REG_STAT);

  wire [CNT_W-1:0] pix_cnt;
  wire [CNT_W-1:0] line_cnt;
  wire [CNT_W-1:0] line_nx;

  wire [31:0] stat_word = ({20'h0_0000, pix_cnt} << vq_pkg::STAT_PIX_LSB)
                        | ({20'h0_0000, line_cnt} << vq_pkg::STAT_LINE_LSB);

  // Unmapped offsets answer with zero and swallow writes
  wire [31:0] rd_mux = hit_ctrl ? ctrl_reg :
                       hit_hwin ? hwin_reg :
                       hit_vwin ? vwin_reg :
                       hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_state_reg <= vq_pkg::BUS_IDLE;
      wb_ack_o      <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
    end else begin
      case (bus_state_reg)
        vq_pkg::BUS_IDLE: begin
          wb_ack_o <= req;
          if (req) begin
            bus_state_reg <= vq_pkg::BUS_ACK;
            rdata_reg     <= rd_mux;
          end
        end
        vq_pkg::BUS_ACK: begin
          wb_ack_o      <= 1'b0;
          bus_state_reg <= vq_pkg::BUS_IDLE;
        end
        default: begin
          wb_ack_o      <= 1'b0;
          bus_state_reg <= vq_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign wb_dat_o = rdata_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= vq_pkg::CTRL_RST;
      hwin_reg <= vq_pkg::HWIN_RST;
      vwin_reg <= vq_pkg::VWIN_RST;
    end else if (wr) begin
      if (hit_ctrl) begin
        ctrl_reg <= lanes(ctrl_reg, wb_dat_i, wb_sel_i);
      end
      if (hit_hwin) begin
        hwin_reg <= lanes(hwin_reg, wb_dat_i, wb_sel_i);
      end
      if (hit_vwin) begin
        vwin_reg <= lanes(vwin_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire             cut_en   = ctrl_reg[vq_pkg::CTRL_EN_BIT];
  wire             trs_mode = ctrl_reg[vq_pkg::CTRL_TRS_BIT];
  wire vq_pkg::qsel_t qsel  = vq_pkg::qsel_t'(ctrl_reg[vq_pkg::CTRL_QSEL_LSB +: 3]);
  wire [CNT_W-1:0] left_blank_pixel_count = hwin_reg[vq_pkg::WIN_FIRST_LSB +: CNT_W];
  wire [CNT_W-1:0] kept_pixel_count       = hwin_reg[vq_pkg::WIN_SIZE_LSB +: CNT_W];
  wire [CNT_W-1:0] top_blank_line_count   = vwin_reg[vq_pkg::WIN_FIRST_LSB +: CNT_W];
  wire [CNT_W-1:0] kept_line_count        = vwin_reg[vq_pkg::WIN_SIZE_LSB +: CNT_W];

  // ----------------------------------------------------------------
  // Pixel and line position
  // ----------------------------------------------------------------
  logic h_act_d_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      h_act_d_reg <= 1'b0;
    end else begin
      h_act_d_reg <= vin.h_act;
    end
  end

  wire line_end = h_act_d_reg && !vin.h_act;

  // Held at zero through blanking, so the first active pixel is index 0
  span_counter #(.W(CNT_W)) u_pix (
    .core_clk (core_clk),
    .nrst     (nrst),
    .restart  (!vin.h_act),
    .advance  (vin.h_act),
    .cnt      (pix_cnt),
    .cnt_next ()
  );

  // Advances at end of line; during the EAV the new index is only on cnt_next
  span_counter #(.W(CNT_W)) u_line (
    .core_clk (core_clk),
    .nrst     (nrst),
    .restart  (!vin.v_act),
    .advance  (line_end),
    .cnt      (line_cnt),
    .cnt_next (line_nx)
  );

  // Sum kept one bit wider so a window reaching the end does not wrap
  function automatic logic in_span(input logic [CNT_W-1:0] idx,
                                   input logic [CNT_W-1:0] first,
                                   input logic [CNT_W-1:0] size);
    logic [CNT_W:0] stop;
    stop = {1'b0, first} + {1'b0, size};
    return (idx >= first) && ({1'b0, idx} < stop);
  endfunction

  wire h_in = !cut_en ||
              in_span(pix_cnt, left_blank_pixel_count,
                      kept_pixel_count);
  wire v_in = !cut_en ||
              in_span(line_cnt, top_blank_line_count,
                      kept_line_count);
  wire v_in_nx = vin.v_act && (!cut_en ||
                 in_span(line_nx, top_blank_line_count, kept_line_count));

  wire active = vin.h_act && vin.v_act;
  wire in_win = h_in && v_in;

  // ----------------------------------------------------------------
  // Quantizing
  // ----------------------------------------------------------------
  wire [11:0] y_q;
  wire [11:0] c_q;

  sample_quantizer u_qy (
    .sel       (qsel),
    .is_chroma (1'b0),
    .din       (vin.y),
    .dout      (y_q)
  );

  sample_quantizer u_qc (
    .sel       (qsel),
    .is_chroma (1'b1),
    .din       (vin.c),
    .dout      (c_q)
  );

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Non-active words pass untouched so embedded timing stays in place
  wire [11:0] y_next = !active ? vin.y :
                       in_win  ? y_q : vq_pkg::BLANK_Y;
  wire [11:0] c_next = !active ? vin.c :
                       in_win  ? c_q : vq_pkg::BLANK_C;

  // Embedded timing: vertical and field only move with EAV
  wire vf_load = !trs_mode || vin.eav;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      vout <= '{h_out: 1'b0, v_out: 1'b0, f_out: 1'b0,
                y: vq_pkg::BLANK_Y, c: vq_pkg::BLANK_C};
    end else begin
      vout.y     <= y_next;
      vout.c     <= c_next;
      vout.h_out <= active && in_win;
      if (vf_load) begin
        vout.v_out <= v_in_nx;
        vout.f_out <= vin.field;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_blank_outside: assert property (active && cut_en && !in_win |=>
    vout.y == vq_pkg::BLANK_Y && vout.c == vq_pkg::BLANK_C && !vout.h_out)
    else $error("sample outside window not blanked");
  chk_trs_untouched: assert property (!active |=>
    vout.y == $past(vin.y) && vout.c == $past(vin.c))
    else $error("non-active word altered");
  chk_cut_off_pass: assert property (active && !cut_en |=> vout.h_out)
    else $error("picture cut while cut disabled");
  chk_left_blank: assert property (active && cut_en &&
    pix_cnt < left_blank_pixel_count |=> vout.y == vq_pkg::BLANK_Y)
    else $error("left pixel not blanked");
  chk_kept_span: assert property (active && cut_en && v_in &&
    pix_cnt >= left_blank_pixel_count &&
    {1'b0, pix_cnt} < {1'b0, left_blank_pixel_count} + {1'b0, kept_pixel_count}
    |=> vout.h_out)
    else $error("kept pixel not flagged");
  chk_top_blank: assert property (active && cut_en &&
    line_cnt < top_blank_line_count |=> !vout.h_out)
    else $error("top line not blanked");
  chk_vf_on_eav: assert property (trs_mode && !vin.eav |=>
    $stable(vout.v_out) && $stable(vout.f_out))
    else $error("vertical or field flag moved off EAV");
  chk_full_pass: assert property (active && in_win &&
    (qsel == vq_pkg::Q_FULL) |=> vout.y == $past(vin.y))
    else $error("full resolution sample altered");
  chk_q10_grid: assert property (active && in_win &&
    (qsel == vq_pkg::Q_10B) |=> vout.y[1:0] == 2'h0 &&
    vout.y >= 12'h010 && vout.y <= 12'hFEC)
    else $error("10-bit range 2 violated");
  chk_q8_limits: assert property (active && in_win &&
    (qsel == vq_pkg::Q_8C) |=> vout.y[3:0] == 4'h0 &&
    vout.y >= 12'h100 && vout.y <= 12'hEB0 && vout.c <= 12'hF00)
    else $error("8-bit studio range violated");
  chk_pix_restart: assert property (vin.h_act && !h_act_d_reg |->
    pix_cnt == '0)
    else $error("pixel count not restarted");
  chk_bus_ack: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

  // ----------------------------------------------------------------
  // Window edge and range checks
  // ----------------------------------------------------------------
  // Window ends one bit wider, as in in_span
  wire [CNT_W:0] h_stop = {1'b0, left_blank_pixel_count} + {1'b0, kept_pixel_count};
  wire [CNT_W:0] v_stop = {1'b0, top_blank_line_count} + {1'b0, kept_line_count};

  chk_h_out_idle: assert property (!active |=> !vout.h_out)
    else $error("line flag set outside active picture");
  chk_v_out_idle: assert property (!trs_mode && !vin.v_act |=> !vout.v_out)
    else $error("vertical flag set in vertical blanking");
  chk_right_blank: assert property (active && cut_en &&
    {1'b0, pix_cnt} >= h_stop |=>
    vout.y == vq_pkg::BLANK_Y && vout.c == vq_pkg::BLANK_C)
    else $error("pixel right of window not blanked");
  chk_kept_lines: assert property (active && cut_en && h_in &&
    line_cnt >= top_blank_line_count && {1'b0, line_cnt} < v_stop
    |=> vout.h_out)
    else $error("kept line not flagged");
  chk_lines_below: assert property (active && cut_en &&
    {1'b0, line_cnt} >= v_stop |=> !vout.h_out && vout.y == vq_pkg::BLANK_Y)
    else $error("line below window not blanked");
  chk_chroma_blank: assert property (active && cut_en && !v_in |=>
    vout.c == vq_pkg::BLANK_C)
    else $error("chroma outside window not at blank");
  chk_line_restart: assert property (!vin.v_act |=> line_cnt == '0)
    else $error("line count not restarted");
  chk_field_follow: assert property (!trs_mode |=> vout.f_out == $past(vin.field))
    else $error("field flag does not follow input");
  chk_field_on_eav: assert property (trs_mode && vin.eav |=>
    vout.f_out == $past(vin.field))
    else $error("field flag not loaded on EAV");
  chk_q10_full: assert property (active && in_win &&
    (qsel == vq_pkg::Q_10A) |=> vout.y[1:0] == 2'h0 && vout.c[1:0] == 2'h0)
    else $error("10-bit range 1 off grid");
  chk_q10_studio: assert property (active && in_win &&
    (qsel == vq_pkg::Q_10C) |=> vout.y >= 12'h100 && vout.y <= 12'hEB0 &&
    vout.c >= 12'h100 && vout.c <= 12'hF00)
    else $error("10-bit range 3 violated");
  chk_q8_grid: assert property (active && in_win &&
    (qsel == vq_pkg::Q_8A) |=> vout.y[3:0] == 4'h0 && vout.c[3:0] == 4'h0)
    else $error("8-bit range 1 off grid");
  chk_q8_narrow: assert property (active && in_win &&
    (qsel == vq_pkg::Q_8B) |=> vout.y >= 12'h010 && vout.y <= 12'hFE0 &&
    vout.c >= 12'h010 && vout.c <= 12'hFE0)
    else $error("8-bit range 2 violated");

  cov_cut_line: cover property (cut_en && active && in_win ##1
    cut_en && active && !in_win);
  cov_eav_move: cover property (trs_mode && vin.eav ##1 $changed(vout.v_out));
  cov_clip_low: cover property (active && in_win && qsel == vq_pkg::Q_8C &&
    vin.y < 12'h100);
  cov_write_ctrl: cover property (wr && hit_ctrl);
endmodule
`default_nettype wire

// ---- dv/video_sink.sv ----
// Purpose: downstream sink that measures the cropped picture
// Assumes: samples vout on every rising edge of core_clk
// Notes:   observes only, it never stalls the stream
`default_nettype none
module video_sink (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire vq_pkg::vid_out_t vout,
  output logic [11:0]           line_px,
  output logic [11:0]           field_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        h_reg;
  logic        v_reg;
  logic [11:0] px_reg;
  logic [11:0] ln_reg;
  wire         h_fall  = h_reg & ~vout.h_out;
  wire         v_fall  = v_reg & ~vout.v_out;
  // Last line and window end can fall on one edge
  wire  [11:0] ln_next = ln_reg + {11'h000, h_fall};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      h_reg       <= 1'b0;
      v_reg       <= 1'b0;
      px_reg      <= 12'h000;
      ln_reg      <= 12'h000;
      line_px     <= 12'h000;
      field_lines <= 12'h000;
    end else begin
      h_reg  <= vout.h_out;
      v_reg  <= vout.v_out;
      px_reg <= h_fall ? 12'h000 : px_reg + {11'h000, vout.h_out};
      ln_reg <= v_fall ? 12'h000 : ln_next;
      if (h_fall) line_px <= px_reg;
      if (v_fall) field_lines <= ln_next;
    end
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the crop and quantize stage
// Assumes: one sample per clock, one cycle from vin to vout
// Notes:   expected words come from a reference model of the window
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic             core_clk;
  logic             nrst;
  logic             wb_cyc_i;
  logic             wb_stb_i;
  logic             wb_we_i;
  logic [7:0]       wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [31:0]      wb_dat_i;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o;
  vq_pkg::vid_in_t  vin;
  vq_pkg::vid_out_t vout;
  vq_pkg::vid_out_t held;
  vq_pkg::vid_out_t vq[$];
  logic [32:0]      bq[$];
  logic [32:0]      bh;
  logic [11:0]      line_px;
  logic [11:0]      field_lines;
  logic [31:0]      seed;
  logic             ph, pv, ve, fe, fld;
  logic             armed = 1'b0;
  int               fail_count, n_compared, en, trs, sel, hl, hk, vt, vk, pi, li;

  crop_quant_top #(.CNT_W(12)) DUT (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vin(vin), .vout(vout));
  video_sink sink (.core_clk(core_clk), .nrst(nrst), .vout(vout), .line_px(line_px),
    .field_lines(field_lines));

  // ----------------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [11:0] q(input bit ch, input logic [11:0] d);
    int r, lo, hi, sh;
    sh = sel >= 5 ? 4 : 2;
    case (sel)
      1: {lo, hi} = {32'd0, 32'd1023};
      2: {lo, hi} = {32'd4, 32'd1019};
      3: {lo, hi} = {32'd64, ch ? 32'd960 : 32'd940};
      5: {lo, hi} = {32'd0, 32'd255};
      6: {lo, hi} = {32'd1, 32'd254};
      7: {lo, hi} = {32'd16, ch ? 32'd240 : 32'd235};
      default: return d;
    endcase
    r = (int'(d) + (1 << (sh - 1))) >> sh;
    r = r < lo ? lo : r > hi ? hi : r;
    return 12'(r << sh);
  endfunction

  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_vid(input vq_pkg::vid_out_t e, input vq_pkg::vid_out_t g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected vout expected %h seen %h", e, g);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, input logic [31:0] e);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    bq.push_back({~we, e});
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic set_crop(input int e, t, s, a, b, c, d);
    {en, trs, sel, hl, hk, vt, vk} = {e, t, s, a, b, c, d};
    bus(1'b1, vq_pkg::REG_CTRL, 4'hF, 32'(e | (s << 4) | (t << 8)), 32'h0);
    bus(1'b1, vq_pkg::REG_HWIN, 4'hF, 32'(a | (b << 16)), 32'h0);
    bus(1'b1, vq_pkg::REG_VWIN, 4'hF, 32'(c | (d << 16)), 32'h0);
  endtask

  task automatic drive(input logic h, input logic v, input logic e);
    vq_pkg::vid_in_t  s;
    vq_pkg::vid_out_t x;
    logic             a, hw, vw;
    logic [31:0]      r;
    r = xs();
    {s.h_act, s.v_act, s.field, s.eav} = {h, v, fld, e};
    s.y = (r[2:0] == 3'h0) ? 12'hFFF : r[11:0];
    s.c = (r[5:3] == 3'h1) ? 12'h000 : r[23:12];
    if (v && !pv) li = 0;
    else if (ph && !h) li++;
    if (h) pi = ph ? pi + 1 : 0;
    {ph, pv} = {h, v};
    a = h && v;
    hw = en == 0 || (pi >= hl && pi < hl + hk);
    vw = en == 0 || (li >= vt && li < vt + vk);
    x.h_out = a && hw && vw;
    if (trs == 0 || e) begin
      ve = v && vw;
      fe = fld;
    end
    {x.v_out, x.f_out} = {ve, fe};
    x.y = !a ? s.y : x.h_out ? q(1'b0, s.y) : vq_pkg::BLANK_Y;
    x.c = !a ? s.c : x.h_out ? q(1'b1, s.c) : vq_pkg::BLANK_C;
    @(posedge core_clk);
    vin <= s;
    vq.push_back(x);
  endtask

  task automatic field(input int w, input int l);
    fld = ~fld;
    drive(1'b0, 1'b0, 1'b0);
    drive(1'b0, 1'b0, 1'b1);
    repeat (l) begin
      repeat (w) drive(1'b1, 1'b1, 1'b0);
      drive(1'b0, 1'b1, 1'b1);
      drive(1'b0, 1'b1, 1'b0);
      drive(1'b0, 1'b1, 1'b0);
    end
    drive(1'b0, 1'b0, 1'b1);
    drive(1'b0, 1'b0, 1'b0);
  endtask

  task automatic sink_chk(input int p, input int l);
    repeat (3) @(negedge core_clk);
    cmp32("line_px", p, 32'(line_px));
    cmp32("field_lines", l, 32'(field_lines));
  endtask

  // ----------------------------------------------------------------
  // Processes
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Each note is compared on the falling edge one cycle after its sample was applied
  always @(negedge core_clk) begin
    if (armed) cmp_vid(held, vout);
    armed = vq.size() > 0;
    if (armed) held = vq.pop_front();
  end

  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && bq.size() > 0) begin
      bh = bq.pop_front();
      if (bh[32]) cmp32("wb_dat_o", bh[31:0], wb_dat_o);
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    vin = '0;
    seed = 32'h0001_0371;
    {ph, pv, ve, fe, fld} = '0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    cmp_vid({3'b000, 12'h100, 12'h800}, vout);
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    for (int a = 0; a < 3; a++) bus(1'b0, 8'(a * 4), 4'hF, 32'h0, 32'h0);
    bus(1'b1, 8'h10, 4'hF, xs(), 32'h0);
    bus(1'b0, 8'h10, 4'hF, 32'h0, 32'h0);
    bus(1'b1, vq_pkg::REG_HWIN, 4'hF, 32'h1234_5678, 32'h0);
    bus(1'b1, vq_pkg::REG_HWIN, 4'h5, 32'hAABB_CCDD, 32'h0);
    bus(1'b0, vq_pkg::REG_HWIN, 4'hF, 32'h0, 32'h12BB_56DD);
    done("registers");
    set_crop(0, 0, 0, 2, 3, 1, 2);
    field(8, 4);
    sink_chk(8, 4);
    bus(1'b1, vq_pkg::REG_STAT, 4'hF, xs(), 32'h0);
    // Counters rest at zero once the stream has gone idle
    bus(1'b0, vq_pkg::REG_STAT, 4'hF, 32'h0, {4'h0, pv ? 12'(li) : 12'h000, 4'h0,
        ph ? 12'(pi + 1) : 12'h000});
    done("pass through");
    for (int s = 0; s < 8; s++) begin
      set_crop(1, 0, s == 4 ? 0 : s, 2, 3, 1, 2);
      field(7, 5);
      sink_chk(3, 2);
    end
    set_crop(1, 0, 7, 0, 4095, 3, 1);
    field(6, 5);
    sink_chk(6, 1);
    done("crop and quantize");
    set_crop(1, 1, 3, 1, 4, 2, 2);
    field(6, 5);
    field(6, 5);
    done("embedded timing");
    repeat (3) @(negedge core_clk);
    end_of_test();
  end
endmodule
`default_nettype wire
